//--- rtl/flash_host_ctrl.sv
// apb-controlled host that drives a parallel nor flash command interface
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - identification mode holds until reset written
// - timing-limit flag needs reset to recover
// - program is four writes, last starts it
// - chip erase is six writes ending 10h
// - sector erase is six writes ending sector 30h
// - host spaces sector writes under 50us; timed here from our own done pulse, so an add can land just past 50us
// - other command in window aborts to read
// - unlock AA@555, 55@2AA, then command codes
// - write needs ce, we low and oe high
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int WINDOW_LIMIT = WINDOW_CYC  // shorten in simulation
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  dq_in,
  output flash_pins_s      flash
);
  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEQ  = 4'b0010,   // issuing command writes
    ST_RD   = 4'b0100,   // single array or ident read
    ST_POLL = 4'b1000    // watching the busy bit toggle
  } state_e;

  state_e      state;
  logic [3:0]  op;          // operation in progress or last done
  logic [18:0] tgt_addr;    // software address register
  logic [7:0]  tgt_data;    // software write data register
  logic [2:0]  step;        // index within command sequence
  logic        waiting;     // bus cycle in flight
  logic        fail;        // timing limit seen or request refused
  logic [7:0]  last_rd;     // last byte read from the flash
  logic        poll_valid;  // last_rd holds an earlier poll sample
  logic [12:0] win_cnt;     // cycles since last sector erase write
  logic        win_open;    // accumulation window believed open
  logic        win_lapsed;  // window ran out since last sector write

  // ----------------------------------------------------------------
  // command sequence table
  // ----------------------------------------------------------------
  function automatic seq_word_s seq_word(input logic [3:0] o, input logic [2:0] s,
                                         input logic [18:0] a, input logic [7:0] d);
    seq_word_s w;
    logic [18:0] sect;
    w    = '{UNLOCK1_ADDR, UNLOCK1_DATA, 1'b0};
    sect = {a[18:16], 16'h0000};          // sector select address
    case (o)
      OP_RESET:   w = '{19'h00000, CMD_RESET, 1'b1};
      OP_SUSPEND: w = '{19'h00000, CMD_SUSPEND, 1'b1};
      OP_RESUME:  w = '{19'h00000, CMD_RESUME, 1'b1};
      OP_SECTADD: w = '{sect, CMD_SECTOR, 1'b1};
      default: begin
        // unlock pair for the long sequences
        case (s)
          3'd0: w = '{UNLOCK1_ADDR, UNLOCK1_DATA, 1'b0};
          3'd1: w = '{UNLOCK2_ADDR, UNLOCK2_DATA, 1'b0};
          3'd2: begin
            if (o == OP_IDENT) w = '{UNLOCK1_ADDR, CMD_IDENT, 1'b1};
            else if (o == OP_PROGRAM) w = '{UNLOCK1_ADDR, CMD_PROGRAM, 1'b0};
            else w = '{UNLOCK1_ADDR, CMD_ERASE, 1'b0};
          end
          3'd3: begin
            if (o == OP_PROGRAM) w = '{a, d, 1'b1};
            else w = '{UNLOCK1_ADDR, UNLOCK1_DATA, 1'b0};
          end
          3'd4: w = '{UNLOCK2_ADDR, UNLOCK2_DATA, 1'b0};
          default: begin
            if (o == OP_CHIP) w = '{UNLOCK1_ADDR, CMD_CHIP, 1'b1};
            else w = '{sect, CMD_SECTOR, 1'b1};
          end
        endcase
      end
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire       acc      = psel & penable & pready;       // transfer completes
  wire       hit_cmd  = (paddr == OFS_CMD);
  wire       hit_addr = (paddr == OFS_ADDR);
  wire       hit_wdat = (paddr == OFS_WDATA);
  wire       hit_sts  = (paddr == OFS_STATUS);
  wire       mapped   = hit_cmd | hit_addr | hit_wdat | hit_sts;
  wire       busy     = (state != ST_IDLE);
  wire [3:0] new_op   = pwdata[3:0];
  wire       op_known = (new_op <= OP_RESUME);
  // sector add after the window closed would be taken as a resume or
  // ignored by the flash, so it is refused here instead
  wire       refuse   = (new_op == OP_SECTADD) && !win_open;
  wire       launch   = acc & pwrite & hit_cmd & !busy & op_known & !refuse;
  wire [31:0] status_word = {16'h0000, last_rd, 4'h0, win_open, win_lapsed, fail, busy};
  wire [31:0] rd_mux = hit_cmd  ? {28'h0000000, op} :
                       hit_addr ? {13'h0000, tgt_addr} :
                       hit_wdat ? {24'h000000, tgt_data} :
                       hit_sts  ? status_word : 32'h00000000;

  // ----------------------------------------------------------------
  // bus cycle engine
  // ----------------------------------------------------------------
  seq_word_s  cur;
  logic       cyc_done;
  logic [7:0] cyc_rdata;
  assign cur = seq_word(op, step, tgt_addr, tgt_data);
  wire   reading  = (state == ST_RD) | (state == ST_POLL);
  wire   cyc_go   = busy & !waiting;

  flash_bus_cycle u_cycle (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .start   (cyc_go),
    .wr      (!reading),
    .addr    (reading ? tgt_addr : cur.addr),
    .wdata   (cur.data),
    .dq_in   (dq_in),
    .pins    (flash),
    .done    (cyc_done),
    .rdata   (cyc_rdata)
  );

  wire seq_last   = (state == ST_SEQ) & cyc_done & cur.last;
  wire sect_write = seq_last & ((op == OP_SECTOR) | (op == OP_SECTADD));
  wire toggled    = poll_valid & (cyc_rdata[BIT_ALT_BUSY] != last_rd[BIT_ALT_BUSY]);
  wire settled    = poll_valid & !toggled;
  wire win_end    = (win_cnt == 13'(WINDOW_LIMIT - 1));

  // ----------------------------------------------------------------
  // apb slave: one wait state, then answer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel & penable & !pready;
      prdata  <= (psel & penable & !pready & !pwrite) ? rd_mux : 32'h00000000;
      pslverr <= psel & penable & !pready & !mapped;
    end
  end

  // software address and data registers, held while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_addr <= 19'h00000;
      tgt_data <= 8'h00;
    end else if (clk_en && acc && pwrite && !busy) begin
      if (hit_addr) tgt_addr <= pwdata[18:0];
      if (hit_wdat) tgt_data <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------
  // commands arriving while busy are dropped: the flash would ignore
  // them during an embedded run anyway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      op         <= OP_READ;
      step       <= 3'd0;
      waiting    <= 1'b0;
      fail       <= 1'b0;
      last_rd    <= 8'h00;
      poll_valid <= 1'b0;
    end else if (clk_en) begin
      if (cyc_go) waiting <= 1'b1;
      if (cyc_done) waiting <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (acc && pwrite && hit_cmd && refuse) fail <= 1'b1;
          if (launch) begin
            op    <= new_op;
            step  <= 3'd0;
            fail  <= 1'b0;
            state <= (new_op == OP_READ) ? ST_RD : ST_SEQ;
          end
        end
        ST_SEQ: begin
          if (cyc_done) begin
            step <= step + 3'd1;
            if (cur.last) begin
              poll_valid <= 1'b0;
              // program and chip erase run unattended; poll to the end
              if ((op == OP_PROGRAM) || (op == OP_CHIP)) state <= ST_POLL;
              else state <= ST_IDLE;  // ident stays until reset
            end
          end
        end
        ST_RD: begin
          if (cyc_done) begin
            last_rd <= cyc_rdata;   // array, ident or status byte
            state   <= ST_IDLE;
          end
        end
        ST_POLL: begin
          if (cyc_done) begin
            last_rd    <= cyc_rdata;
            poll_valid <= 1'b1;
            if (settled) begin
              state <= ST_IDLE;
            end else if (toggled && cyc_rdata[BIT_TIMING_LIMIT] && last_rd[BIT_TIMING_LIMIT]) begin
              // limit bit on both reads: a status-to-array change alone
              // must not look like a fault; software must send reset
              fail  <= 1'b1;
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sector erase accumulation window
  // ----------------------------------------------------------------
  // timed from the done pulse of our own final write; the limit is the whole
  // window with no margin kept, which errs on the late side
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt    <= 13'd0;
      win_open   <= 1'b0;
      win_lapsed <= 1'b0;
    end else if (clk_en) begin
      if (sect_write) begin
        win_cnt    <= 13'd0;
        win_open   <= 1'b1;
        win_lapsed <= 1'b0;
      end else if (seq_last) begin
        win_open <= 1'b0;             // other command aborts window
      end else if (win_open) begin
        win_cnt <= win_cnt + 13'd1;
        if (win_end) begin
          win_open   <= 1'b0;
          win_lapsed <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_busy_cmd_drop: assert property (clk_en && acc && pwrite && hit_cmd && busy |=> $stable(op))
    else $error("command accepted while busy");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_prog_then_poll: assert property (clk_en && seq_last && op == OP_PROGRAM |=> state == ST_POLL)
    else $error("program not followed by polling");
  a_reset_code: assert property (cyc_go && op == OP_RESET |-> cur.data == CMD_RESET && cur.last)
    else $error("reset write has wrong code");
  a_unlock_first: assert property (cyc_go && state == ST_SEQ && step == 3'd0 && op == OP_CHIP
                                   |-> cur.addr == UNLOCK1_ADDR && cur.data == UNLOCK1_DATA)
    else $error("sequence does not open with unlock");
  a_window_lapse: assert property ($rose(win_lapsed) |-> $past(win_cnt) == 13'(WINDOW_LIMIT - 1))
    else $error("window lapsed at wrong count");
  a_sect_refused: assert property (clk_en && acc && pwrite && hit_cmd && !busy && refuse
                                   |=> state == ST_IDLE && fail)
    else $error("late sector add not refused");
  a_chip_six_writes: assert property (clk_en && seq_last && op == OP_CHIP |-> step == 3'd5)
    else $error("chip erase not six writes");

  c_program: cover property (clk_en && seq_last && op == OP_PROGRAM ##[1:300] state == ST_IDLE);
  c_sector_add: cover property (clk_en && sect_write && op == OP_SECTADD);
  c_fail: cover property ($rose(fail));
  c_lapse: cover property ($rose(win_lapsed));
endmodule

//--- rtl/flash_host_pkg.sv
// shared constants and types for the parallel flash host controller
package flash_host_pkg;
  // ----------------------------------------------------------------
  // flash pin bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ce_n;    // chip enable, active low
    logic        we_n;    // write enable, active low
    logic        oe_n;    // output enable, active low
    logic [18:0] addr;    // byte address
    logic [7:0]  dq_out;  // data driven toward the flash
    logic        dq_oe;   // high while we drive the data pins
  } flash_pins_s;

  // one write cycle of a command sequence
  typedef struct packed {
    logic [18:0] addr;
    logic [7:0]  data;
    logic        last;    // final write of the sequence
  } seq_word_s;

  localparam flash_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 19'h00000, 8'h00, 1'b0};

  // ----------------------------------------------------------------
  // software register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam int STS_BUSY   = 0;
  localparam int STS_FAIL   = 1;
  localparam int STS_LAPSED = 2;
  localparam int STS_OPEN   = 3;
  localparam int STS_RD_LSB = 8;

  // ----------------------------------------------------------------
  // operation codes written to the command register
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_READ    = 4'h0;
  localparam logic [3:0] OP_RESET   = 4'h1;
  localparam logic [3:0] OP_IDENT   = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h3;
  localparam logic [3:0] OP_CHIP    = 4'h4;
  localparam logic [3:0] OP_SECTOR  = 4'h5;
  localparam logic [3:0] OP_SECTADD = 4'h6;
  localparam logic [3:0] OP_SUSPEND = 4'h7;
  localparam logic [3:0] OP_RESUME  = 4'h8;

  // ----------------------------------------------------------------
  // flash command cycle encodings
  // ----------------------------------------------------------------
  localparam logic [18:0] UNLOCK1_ADDR = 19'h00555;
  localparam logic [18:0] UNLOCK2_ADDR = 19'h002aa;
  localparam logic [7:0]  UNLOCK1_DATA = 8'haa;
  localparam logic [7:0]  UNLOCK2_DATA = 8'h55;
  localparam logic [7:0]  CMD_IDENT    = 8'h90;
  localparam logic [7:0]  CMD_PROGRAM  = 8'ha0;
  localparam logic [7:0]  CMD_ERASE    = 8'h80;
  localparam logic [7:0]  CMD_CHIP     = 8'h10;
  localparam logic [7:0]  CMD_SECTOR   = 8'h30;
  localparam logic [7:0]  CMD_RESET    = 8'hf0;
  localparam logic [7:0]  CMD_SUSPEND  = 8'hb0;
  localparam logic [7:0]  CMD_RESUME   = 8'h30;
  localparam int BIT_TIMING_LIMIT = 5;   // timing_limit_flag
  localparam int BIT_ALT_BUSY     = 6;   // alternating_busy_bit

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 10;
  localparam int T_STROBE_NS  = 90;      // strobe low time, covers read access
  localparam int STROBE_CYC   = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WINDOW_US  = 50;      // sector erase accumulation window
  localparam int WINDOW_CYC   = T_WINDOW_US * 1000 / CLK_NS;
endpackage

//--- rtl/flash_bus_cycle.sv
// one asynchronous flash bus cycle (read or write) paced by pclk
`timescale 1ns/1ps
module flash_bus_cycle
  import flash_host_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        start,    // one-cycle request while idle
  input  wire logic        wr,       // 1 write, 0 read
  input  wire logic [18:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic [7:0]  dq_in,
  output flash_pins_s      pins,
  output logic             done,     // one-cycle pulse at cycle end
  output logic [7:0]       rdata
);
  typedef enum logic [3:0] {
    PH_IDLE   = 4'b0001,
    PH_SETUP  = 4'b0010,
    PH_STROBE = 4'b0100,
    PH_HOLD   = 4'b1000
  } phase_e;

  phase_e     ph;       // cycle phase
  logic [3:0] cnt;      // strobe cycles left
  logic       is_wr;    // latched direction

  wire strobe_end = (cnt == 4'd1);

  // ----------------------------------------------------------------
  // phase sequencer
  // ----------------------------------------------------------------
  // address goes out a cycle before strobes fall and stays through
  // hold, so it is settled at the later falling edge and data is
  // still driven at the earlier rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph    <= PH_IDLE;
      cnt   <= 4'd0;
      is_wr <= 1'b0;
      pins  <= PINS_IDLE;
      done  <= 1'b0;
      rdata <= 8'h00;
    end else if (clk_en) begin
      done <= 1'b0;
      case (ph)
        PH_IDLE: begin
          if (start) begin
            ph          <= PH_SETUP;
            is_wr       <= wr;
            pins.addr   <= addr;
            pins.dq_out <= wdata;
            pins.dq_oe  <= wr;
          end
        end
        PH_SETUP: begin
          // write: ce and we low, oe high; read: ce and oe low
          ph        <= PH_STROBE;
          cnt       <= 4'(STROBE_CYC);
          pins.ce_n <= 1'b0;
          pins.we_n <= ~is_wr;
          pins.oe_n <= is_wr;
        end
        PH_STROBE: begin
          cnt <= cnt - 4'd1;
          if (strobe_end) begin
            ph        <= PH_HOLD;
            pins.ce_n <= 1'b1;
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            if (!is_wr) rdata <= dq_in;
          end
        end
        PH_HOLD: begin
          // release data only after strobes are back high
          ph         <= PH_IDLE;
          pins.dq_oe <= 1'b0;
          done       <= 1'b1;
        end
        default: ph <= PH_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_write_strobe_combo: assert property (!pins.we_n |-> !pins.ce_n && pins.oe_n)
    else $error("write strobe without ce or with oe low");
  a_addr_held_strobe: assert property ((ph == PH_STROBE) && clk_en |=> $stable(pins.addr))
    else $error("address moved during strobe");
  a_data_held_rise: assert property ($rose(pins.we_n) |-> pins.dq_oe)
    else $error("write data released before we rose");
endmodule

//--- bench/flash_device_model.sv
// behavioural parallel flash device facing the host controller
`timescale 1ns/1ps
module flash_device_model
  import flash_host_pkg::*;
#(
  parameter logic [7:0] ID_MAKER = 8'h5a,  // arbitrary value
  parameter logic [7:0] ID_DEV   = 8'hc3,  // arbitrary value
  parameter logic [7:0] ID_CONT  = 8'h6e,  // arbitrary value
  parameter logic [7:0] PROT_MAP = 8'h08   // only sector 3 protected
) (
  input  wire flash_pins_s pins,
  input  wire logic        inject,  // next program hits the timing limit
  output logic [7:0]       dq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]  mem [8];  // tiny array, low address bits only
  logic [18:0] la;       // address latched by a write
  logic [2:0]  st;       // command sequence step
  logic        idm;      // identification mode
  logic        fault;    // timing limit reached
  logic        tog;      // alternating busy bit
  int          busy_n;   // reads left before the embedded op ends
  logic [7:0]  ers;      // sectors picked for erase
  logic        sus;      // erase suspended
  wire wcyc = !pins.ce_n && !pins.we_n && pins.oe_n;  // write needs oe high
  wire rcyc = !pins.ce_n && !pins.oe_n && pins.we_n;
  // identification codes by low address byte, else protection by sector
  wire [7:0] idv = (pins.addr[7:0] == 8'h00) ? ID_MAKER :
                   (pins.addr[7:0] == 8'h01) ? ID_DEV :
                   (pins.addr[7:0] == 8'h11) ? ID_CONT :
                   {7'h00, PROT_MAP[pins.addr[18:16]]};
  // status while busy, faulted or reading a suspended erase sector, otherwise codes or array
  wire [7:0] rdv = fault ? {1'b0, tog, 1'b1, 5'h00} :
                   (busy_n != 0 || (sus && ers[pins.addr[18:16]])) ? {1'b0, tog, 6'h00} :
                   idm ? idv : mem[pins.addr[2:0]];
  // a released bus shows the inverse, never a stale copy
  assign dq = rcyc ? rdv : ~rdv;
  initial begin  // power-up lands in array read
    foreach (mem[i]) mem[i] = 8'hff;
    st = 3'd0;
    idm = 1'b0;
    fault = 1'b0;
    tog = 1'b0;
    busy_n = 0;
    ers = 8'h00;
    sus = 1'b0;
  end
  always @(posedge wcyc) la = pins.addr;  // address on the later fall
  always @(negedge rcyc) begin  // every finished read moves status on
    tog = ~tog;
    if (busy_n != 0) busy_n--;
  end
  // ----------------------------------------------------------------
  // command decoder, data taken on the earlier rise
  // ----------------------------------------------------------------
  always @(negedge wcyc) begin
    if (busy_n != 0) begin
      // embedded op running: writes ignored
    end else if (pins.dq_out == CMD_RESET) begin  // any address
      st = 3'd0;
      idm = 1'b0;
      fault = 1'b0;
    end else if (st == 3'd0 && ers != 8'h00 && !sus && pins.dq_out == CMD_SUSPEND) begin
      sus = 1'b1;  // erase held, other sectors readable
    end else if (st == 3'd0 && sus && pins.dq_out == CMD_RESUME) begin
      sus = 1'b0;  // erase resumes and, in this model, ends at once
      ers = 8'h00;
    end else if (st == 3'd0 && ers != 8'h00 && !sus && pins.dq_out == CMD_SECTOR) begin
      ers[la[18:16]] = 1'b1;  // another sector joins the erase
    end else case (st)
      3'd0: st = (la == UNLOCK1_ADDR && pins.dq_out == UNLOCK1_DATA) ? 3'd1 : 3'd0;
      3'd1: st = (la == UNLOCK2_ADDR && pins.dq_out == UNLOCK2_DATA) ? 3'd2 : 3'd0;
      3'd2: begin  // third write picks the operation
        idm = (pins.dq_out == CMD_IDENT);
        st = (pins.dq_out == CMD_PROGRAM) ? 3'd3 : (pins.dq_out == CMD_ERASE) ? 3'd4 : 3'd0;
      end
      3'd3: begin  // program clears bits only, any order
        mem[la[2:0]] = mem[la[2:0]] & pins.dq_out;
        busy_n = inject ? 0 : 4;
        fault = inject;
        st = 3'd0;
      end
      3'd4: st = (la == UNLOCK1_ADDR && pins.dq_out == UNLOCK1_DATA) ? 3'd5 : 3'd0;
      3'd5: st = (la == UNLOCK2_ADDR && pins.dq_out == UNLOCK2_DATA) ? 3'd6 : 3'd0;
      default: begin  // chip erase runs, sector erase accumulates
        if (pins.dq_out == CMD_CHIP) foreach (mem[i]) mem[i] = 8'hff;
        if (pins.dq_out != CMD_CHIP) ers[la[18:16]] = 1'b1;
        busy_n = (pins.dq_out == CMD_CHIP) ? 6 : 0;
        st = 3'd0;
      end
    endcase
  end
endmodule

//--- bench/flash_host_ctrl_tb.sv
// self-checking bench for the apb flash host controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module flash_host_ctrl_tb
  import flash_host_pkg::*;
;
  localparam int         WLIM     = 200;    // short erase window
  localparam logic [7:0] ID_MAKER = 8'h5a;  // arbitrary value
  localparam logic [7:0] ID_DEV   = 8'hc3;  // arbitrary value
  localparam logic [7:0] ID_CONT  = 8'h6e;  // arbitrary value
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        inject = 1'b0, pready, pslverr;
  logic [7:0]  paddr = 8'h00, dq_in, d1, d2;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [64:0] e;       // popped note
  logic [64:0] q[$];    // {slverr, mask, expected} per transfer
  flash_pins_s flash;
  int          err_count = 0;
  int          n_checks = 0;
  always #5 pclk = ~pclk;
  flash_host_ctrl #(.WINDOW_LIMIT(WLIM)) u_flash_host_ctrl (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dq_in(dq_in),
    .flash(flash));
  flash_device_model #(.ID_MAKER(ID_MAKER), .ID_DEV(ID_DEV), .ID_CONT(ID_CONT))
    u_flash_device_model (.pins(flash), .inject(inject), .dq(dq_in));
  // ----------------------------------------------------------------
  // monitor: each completed transfer is matched against the oldest note
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = q.pop_front();
      `CHK("pslverr", e[64], pslverr)
      if (!pwrite) `CHK("prdata", e[31:0], prdata & e[63:32])
    end
  end
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic err);
    q.push_back({err, m, d & m});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);  // idle gap keeps one assignment per step
  endtask
  // launch an operation and poll until the controller is idle again
  task automatic op(input logic [3:0] o, input logic [18:0] a, input logic [7:0] d);
    apb(1'b1, OFS_ADDR, {13'h0, a}, 32'h0, 1'b0);
    apb(1'b1, OFS_WDATA, {24'h0, d}, 32'h0, 1'b0);
    apb(1'b1, OFS_CMD, {28'h0, o}, 32'h0, 1'b0);
    r = 32'h1;
    while (r[STS_BUSY] !== 1'b0) apb(1'b0, OFS_STATUS, 32'h0, 32'h0, 1'b0);
  endtask
  task automatic sts(input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, OFS_STATUS, x, m, 1'b0);
  endtask
  // one flash read, byte checked in the status register
  task automatic rd(input logic [18:0] a, input logic [7:0] x);
    op(OP_READ, a, 8'h00);
    sts(32'h0000ff03, {16'h0, x, 8'h00});
  endtask
  task automatic print_verdict();
    if (err_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(29));
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(19'h00002, 8'hff);
    apb(1'b0, 8'h10, 32'h0, 32'h0, 1'b1);        // unmapped offset answers with error
    op(OP_PROGRAM, 19'h00002, d1);
    rd(19'h00002, d1);
    op(OP_PROGRAM, 19'h00002, d2);
    rd(19'h00002, d1 & d2);
    op(OP_IDENT, 19'h00000, 8'h00);
    rd(19'h40000, ID_MAKER);
    rd(19'h12301, ID_DEV);
    rd(19'h00011, ID_CONT);
    rd(19'h30002, 8'h01);
    rd(19'h50002, 8'h00);
    op(OP_RESET, 19'h12345, 8'h00);
    rd(19'h00002, d1 & d2);
    op(OP_CHIP, 19'h00000, 8'h00);
    rd(19'h00002, 8'hff);
    inject <= 1'b1;
    op(OP_PROGRAM, 19'h00005, 8'h0f);
    sts(32'h2, 32'h2);
    inject <= 1'b0;
    op(OP_RESET, 19'h00000, 8'h00);
    rd(19'h00003, 8'hff);
    op(OP_SECTOR, 19'h20000, 8'h00);
    sts(32'he, 32'h8);
    op(OP_SECTADD, 19'h60000, 8'h00);
    sts(32'he, 32'h8);
    repeat (WLIM + 20) @(posedge pclk);
    sts(32'hc, 32'h4);
    op(OP_SECTADD, 19'h70000, 8'h00);
    sts(32'h2, 32'h2);
    op(OP_SUSPEND, 19'h00000, 8'h00);
    op(OP_READ, 19'h60003, 8'h00);
    sts(32'h0000bf03, 32'h0);
    rd(19'h00003, 8'hff);
    op(OP_RESET, 19'h00000, 8'h00);
    op(OP_READ, 19'h20003, 8'h00);
    sts(32'h0000bf03, 32'h0);
    op(OP_RESUME, 19'h00000, 8'h00);
    rd(19'h60003, 8'hff);
    print_verdict();
  end
  initial begin  // watchdog well beyond the expected run
    #400000;
    err_count++;
    print_verdict();
  end
endmodule
